// [power_button_control_pkg.sv]
// Purpose: constants shared by the power button controller
// Assumes: 250 MHz clock
// Notes:   guard time scaled to cycles in the package
`default_nettype none
package power_button_control_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint unsigned CLK_HZ        = 64'd250_000_000;
    localparam longint unsigned GUARD_SECONDS = 64'd4;
    localparam longint unsigned GUARD_CYCLES  = GUARD_SECONDS * CLK_HZ;
    localparam int              COUNT_W       = 30;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic SUPPLY_ON_RESET = 1'b0;
    localparam logic STATUS_RESET    = 1'b0;

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_OFF      = 4'h1,
        ST_ON       = 4'h2,
        ST_GUARD    = 4'h4,
        ST_SUSPEND  = 4'h8
    } power_state_type;

endpackage
`default_nettype wire

// [power_button_control.sv]
// Purpose: turns power button pulses into the supply-on request
// Assumes: button_n_in synchronous to mclk_in, already debounced
// Notes:   guard length is a parameter so simulation can shorten it
//          the long-hold timer shares the guard length
//
// How it works
// RQ1 - button gives an active-low pulse; logic acts on its falling edge
// RQ2 - off: falling edge asserts supply-on request, guard counter idle
// RQ3 - on, acpi off: falling edge drops supply-on, no guard counter
// RQ4 - on, acpi on: edge raises management interrupt and source bit
// RQ5 - same edge sets button status bit and starts four-second guard
// RQ6 - software clears status within four seconds to enter suspend
// RQ7 - status still set at guard expiry drops supply-on request
// RQ8 - supply makes main rails while request is asserted
// RQ9 - acpi on: button held four seconds then released drops supply
`default_nettype none
module power_button_control
    import power_button_control_pkg::*;
#(
    parameter logic [COUNT_W-1:0] GUARD_COUNT = COUNT_W'(GUARD_CYCLES)
)
(
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    input  wire logic button_n_in,
    input  wire logic acpi_enable_in,
    input  wire logic status_clear_in,
    input  wire logic source_clear_in,
    input  wire logic suspend_done_in,
    output var  logic supply_on_request_out,
    output var  logic mgmt_interrupt_n_out,
    output var  logic button_source_out,
    output var  logic button_status_out,
    output var  logic guard_active_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    power_state_type    state;
    power_state_type    next_state;
    logic               button_prev;
    logic               supply_on;
    logic               next_supply_on;
    logic               source_bit;
    logic               next_source_bit;
    logic               status_bit;
    logic               next_status_bit;
    logic [COUNT_W-1:0] guard_count;
    logic [COUNT_W-1:0] next_guard_count;
    logic [COUNT_W-1:0] hold_count;
    logic [COUNT_W-1:0] next_hold_count;
    logic               fall_edge;
    logic               rise_edge;
    logic               guard_done;
    logic               held_long;

    // ------------------------------------------------------------
    // button edges
    // ------------------------------------------------------------
    // prev resets high, so a button held at reset release counts as a falling edge
    assign fall_edge  = button_prev & ~button_n_in; // RQ1
    assign rise_edge  = ~button_prev & button_n_in;

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    assign guard_done = (guard_count == GUARD_COUNT);
    assign held_long  = (hold_count == GUARD_COUNT);

    // ------------------------------------------------------------
    // press length
    // ------------------------------------------------------------
    // saturates so a very long hold cannot wrap back to a short one
    always_comb
    begin
        next_hold_count = hold_count;
        if (fall_edge)
        begin
            next_hold_count = COUNT_W'(1);
        end
        else if (button_n_in)
        begin
            next_hold_count = '0;
        end
        else if (!held_long)
        begin
            next_hold_count = hold_count + COUNT_W'(1);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            button_prev <= 1'b1;
            hold_count  <= '0;
        end
        else
        begin
            button_prev <= button_n_in;
            hold_count  <= next_hold_count;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_state       = state;
        next_supply_on   = supply_on;
        next_source_bit  = source_bit & ~source_clear_in;
        next_status_bit  = status_bit & ~status_clear_in;
        next_guard_count = guard_count;
        case (state)
            ST_OFF:
            begin
                next_guard_count = '0;
                if (fall_edge)
                begin
                    next_supply_on = 1'b1; // RQ2
                    next_state     = ST_ON;
                end
            end
            ST_ON:
            begin
                // acpi level matters only on the press edge itself
                next_guard_count = '0;
                if (fall_edge && !acpi_enable_in)
                begin
                    next_supply_on = 1'b0; // RQ3
                    next_state     = ST_OFF;
                end
                else if (fall_edge)
                begin
                    next_source_bit = 1'b1; // RQ4
                    next_status_bit = 1'b1; // RQ5
                    next_state      = ST_GUARD;
                end
            end
            ST_GUARD:
            begin
                // set beats a clear landing in the same cycle
                if (!guard_done)
                begin
                    next_guard_count = guard_count + COUNT_W'(1); // RQ5
                end
                // long hold first: a release beats a pending clear
                if (rise_edge && held_long)
                begin
                    next_supply_on = 1'b0; // RQ9
                    next_state     = ST_OFF;
                end
                else if (!status_bit)
                begin
                    next_state = ST_SUSPEND; // RQ6
                end
                else if (guard_done)
                begin
                    next_supply_on = 1'b0; // RQ7
                    next_state     = ST_OFF;
                end
            end
            ST_SUSPEND:
            begin
                // a long press still forces off before software wakes
                next_guard_count = '0;
                if (rise_edge && held_long)
                begin
                    next_supply_on = 1'b0; // RQ9
                    next_state     = ST_OFF;
                end
                else if (suspend_done_in)
                begin
                    next_state = ST_ON;
                end
            end
            default:
            begin
                // illegal code falls back to off with supply dropped
                next_state     = ST_OFF;
                next_supply_on = SUPPLY_ON_RESET;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // every field resets to a constant, so reset needs no clock
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state       <= ST_OFF;
            supply_on   <= SUPPLY_ON_RESET;
            source_bit  <= STATUS_RESET;
            status_bit  <= STATUS_RESET;
            guard_count <= '0;
        end
        else
        begin
            state       <= next_state;
            supply_on   <= next_supply_on;
            source_bit  <= next_source_bit;
            status_bit  <= next_status_bit;
            guard_count <= next_guard_count;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign supply_on_request_out = supply_on; // RQ8
    // inverted source flop, so the interrupt adds no cycle
    assign mgmt_interrupt_n_out  = ~source_bit; // RQ4
    assign button_source_out     = source_bit;
    assign button_status_out     = status_bit;
    assign guard_active_out      = (state == ST_GUARD);

endmodule
`default_nettype wire

// [pbc_chk.sv]
// Purpose: port checker for power_button_control
// Assumes: GUARD_COUNT shortened for simulation
// Notes:   suspend kept locally, the ports cannot show it
`default_nettype none
module pbc_chk
    import power_button_control_pkg::*;
#(
    parameter logic [COUNT_W-1:0] GUARD_COUNT = COUNT_W'(20)
)
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic button_n_in,
    input wire logic acpi_enable_in,
    input wire logic status_clear_in,
    input wire logic suspend_done_in,
    input wire logic supply_on_request_out,
    input wire logic mgmt_interrupt_n_out,
    input wire logic button_source_out,
    input wire logic button_status_out,
    input wire logic guard_active_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GMAX = int'(GUARD_COUNT) + 3;
    logic in_susp;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    always_ff @(posedge mclk_in or negedge rst_n_in)
        if (!rst_n_in)
            in_susp <= 1'b0;
        else if ($fell(guard_active_out) && supply_on_request_out)
            in_susp <= 1'b1;
        else if (suspend_done_in || !supply_on_request_out)
            in_susp <= 1'b0;
    sequence s_on_press;
        supply_on_request_out && !guard_active_out && !in_susp
            && $fell(button_n_in);
    endsequence
    property p_off_press;
        !supply_on_request_out && $fell(button_n_in)
            |=> supply_on_request_out && !guard_active_out;
    endproperty
    property p_plain_off;
        s_on_press ##0 !acpi_enable_in
            |=> !supply_on_request_out && !guard_active_out;
    endproperty
    property p_irq;
        s_on_press ##0 acpi_enable_in
            |=> !mgmt_interrupt_n_out && button_source_out;
    endproperty
    property p_guard_start;
        s_on_press ##0 acpi_enable_in
            |=> button_status_out && guard_active_out;
    endproperty
    // uncleared guard can only end by shutting down
    property p_expire;
        guard_active_out && button_status_out && !status_clear_in
            ##1 !guard_active_out |-> !supply_on_request_out;
    endproperty
    property p_guard_bound;
        $rose(guard_active_out) |-> ##[1:GMAX] !guard_active_out;
    endproperty
    a_off_press: assert property (p_off_press)
        else $error("off press did not power on");
    a_plain_off: assert property (p_plain_off)
        else $error("plain press did not power off");
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");
    a_guard_start: assert property (p_guard_start)
        else $error("status or guard not started");
    a_expire: assert property (p_expire)
        else $error("guard expiry kept supply on");
    a_guard_bound: assert property (p_guard_bound)
        else $error("guard ran too long");
endmodule
`default_nettype wire

// [panel_model.sv]
// Purpose: power button and supply unit beside the board
// Assumes: presses launched on falling clock edges
// Notes:   main rail follows the request with no ramp delay, standby rail tied on
`default_nettype none
module panel_model
(
    input  wire logic mclk_in,
    input  wire logic supply_on_request_in,
    output var  logic button_n_out,
    output var  logic main_rail_out,
    output var  logic standby_rail_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial button_n_out = 1'b1;
    assign main_rail_out    = supply_on_request_in;
    assign standby_rail_out = 1'b1;
    task automatic press(input int hold);
        @(negedge mclk_in);
        button_n_out = 1'b0;
        repeat (hold) @(negedge mclk_in);
        button_n_out = 1'b1;
    endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Purpose: self-checking bench for power_button_control
// Assumes: guard shortened to G cycles
// Notes:   inputs change on falling edges only
`default_nettype none
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin \
    n_errors++; $display("[ERR] %s exp %b got %b", nm, e, a); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int G = 20;
    logic mclk_in, rst_n_in, button_n_in, acpi_enable_in, status_clear_in;
    logic source_clear_in, suspend_done_in, supply_on_request_out;
    logic mgmt_interrupt_n_out, button_source_out, button_status_out;
    logic guard_active_out, main_rail, standby_rail;
    int   n_errors, checks_done;
    power_button_control #(.GUARD_COUNT(G)) dut (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .button_n_in(button_n_in),
        .acpi_enable_in(acpi_enable_in), .status_clear_in(status_clear_in),
        .source_clear_in(source_clear_in),
        .suspend_done_in(suspend_done_in),
        .supply_on_request_out(supply_on_request_out),
        .mgmt_interrupt_n_out(mgmt_interrupt_n_out),
        .button_source_out(button_source_out),
        .button_status_out(button_status_out),
        .guard_active_out(guard_active_out));
    panel_model pm (
        .mclk_in(mclk_in), .supply_on_request_in(supply_on_request_out),
        .button_n_out(button_n_in), .main_rail_out(main_rail),
        .standby_rail_out(standby_rail));
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic t_power_on;
        pm.press(2);
        `CHK("supply", 1'b1, supply_on_request_out)
        `CHK("guard", 1'b0, guard_active_out)
        `CHK("main_rail", 1'b1, main_rail)
        `CHK("standby_rail", 1'b1, standby_rail)
    endtask
    task automatic t_plain_off;
        acpi_enable_in = 1'b0;
        pm.press(2);
        `CHK("supply", 1'b0, supply_on_request_out)
        `CHK("guard", 1'b0, guard_active_out)
    endtask
    task automatic t_clear;
        acpi_enable_in = 1'b1;
        pm.press(2);
        `CHK("irq_n", 1'b0, mgmt_interrupt_n_out)
        `CHK("source", 1'b1, button_source_out)
        `CHK("status", 1'b1, button_status_out)
        `CHK("guard", 1'b1, guard_active_out)
        status_clear_in = 1'b1;
        source_clear_in = 1'b1;
        tick(1);
        status_clear_in = 1'b0;
        source_clear_in = 1'b0;
        tick(2);
        `CHK("guard", 1'b0, guard_active_out)
        `CHK("supply", 1'b1, supply_on_request_out)
        `CHK("irq_n", 1'b1, mgmt_interrupt_n_out)
        suspend_done_in = 1'b1;
        tick(1);
        suspend_done_in = 1'b0;
    endtask
    task automatic t_expire;
        pm.press(2);
        tick(G - 4);
        `CHK("supply", 1'b1, supply_on_request_out)
        tick(8);
        `CHK("supply", 1'b0, supply_on_request_out)
        `CHK("guard", 1'b0, guard_active_out)
        status_clear_in = 1'b1;
        tick(1);
        status_clear_in = 1'b0;
    endtask
    // status cleared mid-hold, so only the long hold can power off
    task automatic t_long;
        fork
            pm.press(G + 5);
            begin
                tick(4);
                status_clear_in = 1'b1;
                tick(1);
                status_clear_in = 1'b0;
                tick(G - 2);
                `CHK("supply", 1'b1, supply_on_request_out)
            end
        join
        tick(2);
        `CHK("supply", 1'b0, supply_on_request_out)
    endtask
    initial
    begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    initial
    begin
        #40000;
        n_errors++;
        give_verdict();
    end
    initial
    begin
        {rst_n_in, acpi_enable_in, status_clear_in} = 3'h0;
        {source_clear_in, suspend_done_in} = 2'h0;
        tick(8);
        rst_n_in = 1'b1;
        tick(2);
        t_power_on();
        t_plain_off();
        t_power_on();
        t_clear();
        t_expire();
        t_power_on();
        t_long();
        give_verdict();
    end
endmodule
bind power_button_control pbc_chk #(.GUARD_COUNT(GUARD_COUNT)) chk (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .button_n_in(button_n_in),
    .acpi_enable_in(acpi_enable_in), .status_clear_in(status_clear_in),
    .suspend_done_in(suspend_done_in),
    .supply_on_request_out(supply_on_request_out),
    .mgmt_interrupt_n_out(mgmt_interrupt_n_out),
    .button_source_out(button_source_out),
    .button_status_out(button_status_out),
    .guard_active_out(guard_active_out));
`default_nettype wire
